// ===== src/wdt_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define ADDR_WATCHDOG_CONTROL 3'h0
`define ADDR_RESET_SOURCE_FLAGS 3'h1
`define ADDR_PROG_MEM_CTRL_ONE 3'h2
`define ADDR_PORT_DATA 3'h3
`define ADDR_PORT_DIR 3'h4
`define ADDR_STATUS 3'h5
`define WATCHDOG_CONTROL_RESET 8'h53
`define KEY_MSB 7
`define KEY_LSB 3
`define SEL_MSB 2
`define SEL_LSB 0
`define KEY_ENABLE_A 5'h0a
`define KEY_ENABLE_B 5'h15
`define SOFT_FLAG_BIT 0
`define LV_FLAG_BIT 2
`define TO_FLAG_BIT 1
`define PDF_FLAG_BIT 0
`define IAP_RESET_KEY 8'h55
`define PORT_RESET 8'hff
`define FC1_RESET 8'h00
`define LOW_SPEED_CLOCK_HZ 32000
`define CLK_FREQ_HZ 10000000
`define SOFT_RESET_DELAY_NS 10000
`define SOFT_RESET_CYCLES \
  ((`SOFT_RESET_DELAY_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define BROWNOUT_FILTER_NS 100000
`define BROWNOUT_CYCLES \
  ((`BROWNOUT_FILTER_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define WDT_CNT_W 18
`define SOFT_CNT_W 7
`define BROWN_CNT_W 10
`endif

// ===== src/wdt_pkg.sv
// Types shared by the watchdog and reset flag logic
package wdt_pkg;
  // One register bus request, packed from the plain port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Key violation sequencer
  typedef enum {KEY_IDLE, KEY_WAIT} key_state_t;

  // Reset requests raised in one cycle
  typedef struct packed {
    logic full;
    logic pc_sp;
  } reset_req_t;
endpackage

// ===== src/low_speed_internal_osc_tick.sv
// Low-speed oscillator synchroniser and rising edge tick
`timescale 1ns/1ns
module low_speed_internal_osc_tick (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Oscillator pin and tick out
  input wire logic low_speed_clock,
  output logic tick
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic tick_r;

  // Two flops before use; the first is read by the second only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= low_speed_clock;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // One system cycle per oscillator rising edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= sync_r & ~last_r; // R1
    end
  end

  assign tick = tick_r;
endmodule

// ===== src/watchdog_and_reset_flags.sv
// Watchdog timer with key control, reset flags and reset sources
//
// Operation
// R1 - Counter advances only on low-speed oscillator edges
// R2 - Selector picks 2^8 to 2^18 period
// R3 - Keys 01010B or 10101B enable counting
// R4 - Other key values reset after fixed delay
// R5 - Key violation reset sets soft flag
// R6 - Power-on key 01010B, selector 011
// R7 - Soft flag cleared only by software
// R8 - Running timeout: full reset, timeout flag set
// R9 - Low-power timeout: flag, clear PC/SP only
// R10 - Key reset, clear, HALT clear counter
// R11 - Program clears watchdog before period ends
// R12 - Low supply resets only past filter time
// R13 - Brownout reset sets low-voltage flag bit 2
// R14 - Brownout detection off in sleep/idle
// R15 - Power-on clears program counter
// R16 - Power-on sets port data/direction ones
// R17 - Writing 55H to programming control resets
// R18 - Unused reset flag bits read zero
// R19 - HALT sets power-down, clears timeout flag
// R20 - Power-on clears flags; brownout keeps them
// R21 - Control write restarts watchdog count
// R22 - Free 18-bit counter, single-cycle overflow
`timescale 1ns/1ns
`include "wdt_consts.svh"
module watchdog_and_reset_flags
  import wdt_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous pins
  input wire logic low_speed_clock,
  input wire logic low_supply,
  // Core events
  input wire logic clear_watchdog_instr,
  input wire logic halt_instr,
  input wire logic low_power_mode,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Reset requests and status
  output logic full_reset,
  output logic pc_sp_clear,
  output logic timeout_status_flag,
  output logic power_down_flag,
  // Port initial state
  output logic [7:0] port_data,
  output logic [7:0] port_dir
);
  localparam int SR_CYC = `SOFT_RESET_CYCLES;

  reg_req_t req;
  reset_req_t rst_req;
  key_state_t key_state_r;
  logic [7:0] watchdog_control_r;
  logic [7:0] fc1_r;
  logic [7:0] port_data_r;
  logic [7:0] port_dir_r;
  logic [7:0] rdata_r;
  logic [`WDT_CNT_W-1:0] wdt_cnt_r;
  logic [`SOFT_CNT_W-1:0] soft_cnt_r;
  logic [`BROWN_CNT_W-1:0] brown_cnt_r;
  logic soft_flag_r, lv_flag_r, to_flag_r, pdf_r;
  logic full_reset_r;
  logic pc_sp_clear_r;
  logic ls_meta_r, ls_sync_r, lvr_done_r;
  logic tick, key_ok, wdt_ovf, key_rst;
  logic lvr_fire, iap_fire, watchdog_control_wr, reset_source_flags_wr, clear_any;

  // Terminal count for a period code
  function automatic logic [`WDT_CNT_W-1:0] period_term(
    input logic [2:0] sel
  );
    logic [4:0] e;
    logic [`WDT_CNT_W:0] p;
    e = 5'h08;
    unique case (sel)
      3'h0: e = 5'h08;
      3'h1: e = 5'h0a;
      3'h2: e = 5'h0c;
      3'h3: e = 5'h0e;
      3'h4: e = 5'h0f;
      3'h5: e = 5'h10;
      3'h6: e = 5'h11;
      3'h7: e = 5'h12;
    endcase
    p = (19'h1 << e) - 19'h1;
    return p[`WDT_CNT_W-1:0];
  endfunction

  // True for the two enabling key patterns
  function automatic logic key_valid(input logic [7:0] ctl);
    return ctl[`KEY_MSB:`KEY_LSB] == `KEY_ENABLE_A ||
           ctl[`KEY_MSB:`KEY_LSB] == `KEY_ENABLE_B;
  endfunction

  // Oscillator edges arrive as single system-cycle ticks
  low_speed_internal_osc_tick u_tick (
    .clk(clk),
    .rstn(rstn),
    .low_speed_clock(low_speed_clock),
    .tick(tick)
  );

  // Bus request and decoded write strobes
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign watchdog_control_wr = req.wr && req.addr == `ADDR_WATCHDOG_CONTROL;
  assign reset_source_flags_wr = req.wr && req.addr == `ADDR_RESET_SOURCE_FLAGS;
  assign iap_fire = req.wr && req.addr == `ADDR_PROG_MEM_CTRL_ONE &&
                    req.wdata == `IAP_RESET_KEY; // R17

  // Enable decode and overflow on the selected period
  assign key_ok = key_valid(watchdog_control_r); // R3
  assign wdt_ovf = tick && key_ok &&
                   wdt_cnt_r == period_term(watchdog_control_r[`SEL_MSB:`SEL_LSB]);
  assign key_rst = key_state_r == KEY_WAIT &&
                   soft_cnt_r == `SOFT_CNT_W'(SR_CYC - 1);
  assign clear_any = clear_watchdog_instr || halt_instr ||
                     key_rst || watchdog_control_wr; // R10 R21

  // A timeout in sleep or idle only clears PC and SP
  always_comb begin
    rst_req.full = key_rst || lvr_fire || iap_fire ||
                   (wdt_ovf && !low_power_mode); // R4 R8 R12 R17
    rst_req.pc_sp = rst_req.full || (wdt_ovf && low_power_mode); // R9
  end

  // Free 18-bit count of oscillator ticks, cleared on any restart
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdt_cnt_r <= '0;
    end else if (clear_any || rst_req.full || wdt_ovf) begin
      wdt_cnt_r <= '0; // R10 R21 R22
    end else if (tick && key_ok) begin
      wdt_cnt_r <= wdt_cnt_r + `WDT_CNT_W'(1); // R1 R2
    end
  end

  // Once a bad key is seen the reset is committed; rewriting the
  // key during the delay cannot cancel it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      key_state_r <= KEY_IDLE;
      soft_cnt_r <= '0;
    end else begin
      unique case (key_state_r)
        KEY_IDLE: begin
          soft_cnt_r <= '0;
          if (!key_ok) begin
            key_state_r <= KEY_WAIT; // R4
          end
        end
        KEY_WAIT: begin
          if (key_rst) begin
            key_state_r <= KEY_IDLE;
            soft_cnt_r <= '0;
          end else begin
            soft_cnt_r <= soft_cnt_r + `SOFT_CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Control register; any full reset reloads the power-on value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      watchdog_control_r <= `WATCHDOG_CONTROL_RESET; // R6
    end else if (rst_req.full) begin
      watchdog_control_r <= `WATCHDOG_CONTROL_RESET;
    end else if (watchdog_control_wr) begin
      watchdog_control_r <= req.wdata;
    end
  end

  // Programming control holds its last write; any full reset clears it, so a 55H write is never held
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fc1_r <= `FC1_RESET;
    end else if (rst_req.full) begin
      fc1_r <= `FC1_RESET;
    end else if (req.wr && req.addr == `ADDR_PROG_MEM_CTRL_ONE) begin
      fc1_r <= req.wdata;
    end
  end

  // Port registers come up as inputs after any full reset
  always_ff @(posedge clk) begin
    if (!rstn || rst_req.full) begin
      port_data_r <= `PORT_RESET; // R16
      port_dir_r <= `PORT_RESET; // R16
    end else if (req.wr && req.addr == `ADDR_PORT_DATA) begin
      port_data_r <= req.wdata;
    end else if (req.wr && req.addr == `ADDR_PORT_DIR) begin
      port_dir_r <= req.wdata;
    end
  end

  // Soft reset flag: hardware sets, only software clears, set wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_flag_r <= 1'b0;
    end else if (key_rst) begin
      soft_flag_r <= 1'b1; // R5 R7
    end else if (reset_source_flags_wr) begin
      soft_flag_r <= req.wdata[`SOFT_FLAG_BIT]; // R7
    end
  end

  // Low-voltage flag, same set-over-clear policy
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lv_flag_r <= 1'b0;
    end else if (lvr_fire) begin
      lv_flag_r <= 1'b1; // R13
    end else if (reset_source_flags_wr) begin
      lv_flag_r <= req.wdata[`LV_FLAG_BIT]; // R13
    end
  end

  // Supply monitor pin needs two flops before the filter sees it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ls_meta_r <= 1'b0;
      ls_sync_r <= 1'b0;
    end else begin
      ls_meta_r <= low_supply;
      ls_sync_r <= ls_meta_r;
    end
  end

  // Glitch filter: fires once per low-supply episode, and is held
  // off in low-power modes so a sleeping part never browns out
  assign lvr_fire = ls_sync_r && !low_power_mode && !lvr_done_r &&
                    brown_cnt_r == `BROWN_CNT_W'(`BROWNOUT_CYCLES);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      brown_cnt_r <= '0;
      lvr_done_r <= 1'b0;
    end else if (!ls_sync_r || low_power_mode) begin
      brown_cnt_r <= '0; // R12 R14
      lvr_done_r <= 1'b0;
    end else if (lvr_fire) begin
      lvr_done_r <= 1'b1;
    end else if (!lvr_done_r) begin
      brown_cnt_r <= brown_cnt_r + `BROWN_CNT_W'(1); // R12
    end
  end

  // Timeout flag: overflow sets and wins over HALT's clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      to_flag_r <= 1'b0; // R20
    end else if (wdt_ovf) begin
      to_flag_r <= 1'b1; // R8 R9
    end else if (halt_instr) begin
      to_flag_r <= 1'b0; // R19
    end
  end

  // Power-down flag: HALT sets, clear instruction clears
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pdf_r <= 1'b0; // R20
    end else if (halt_instr) begin
      pdf_r <= 1'b1; // R19
    end else if (clear_watchdog_instr) begin
      pdf_r <= 1'b0; // R19
    end
  end

  // Reset pulses; PC clear is held through power-on reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      full_reset_r <= 1'b0;
      pc_sp_clear_r <= 1'b1; // R15
    end else begin
      full_reset_r <= rst_req.full;
      pc_sp_clear_r <= rst_req.pc_sp;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rstn || !req.rd) begin
      rdata_r <= 8'h00;
    end else begin
      unique case (req.addr)
        `ADDR_WATCHDOG_CONTROL: rdata_r <= watchdog_control_r;
        `ADDR_RESET_SOURCE_FLAGS: rdata_r <= {5'h00, lv_flag_r, 1'b0,
                                             soft_flag_r}; // R18
        `ADDR_PROG_MEM_CTRL_ONE: rdata_r <= fc1_r;
        `ADDR_PORT_DATA: rdata_r <= port_data_r;
        `ADDR_PORT_DIR: rdata_r <= port_dir_r;
        `ADDR_STATUS: rdata_r <= {6'h00, to_flag_r, pdf_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_r;
  assign full_reset = full_reset_r;
  assign pc_sp_clear = pc_sp_clear_r;
  assign timeout_status_flag = to_flag_r;
  assign power_down_flag = pdf_r;
  assign port_data = port_data_r;
  assign port_dir = port_dir_r;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_key_bad;
    $rose(key_state_r == KEY_WAIT);
  endsequence
  sequence s_run_ovf;
    wdt_ovf && !low_power_mode;
  endsequence
  sequence s_sleep_ovf;
    wdt_ovf && low_power_mode;
  endsequence
  a_key_delay: assert property (s_key_bad |-> ##SR_CYC full_reset_r) // R4
    else $error("key violation reset not at fixed delay");
  a_soft_set: assert property (key_rst |=> soft_flag_r) // R5
    else $error("soft flag not set by key reset");
  a_soft_hold: assert property (soft_flag_r && !reset_source_flags_wr |=> soft_flag_r) // R7
    else $error("soft flag cleared by hardware");
  a_count_step: assert property (tick && key_ok && !clear_any && // R3
      !rst_req.full && !wdt_ovf |=> wdt_cnt_r == $past(wdt_cnt_r) + 18'h1)
    else $error("enabled counter did not step");
  a_stall_bad_key: assert property (!key_ok && !clear_any && // R3
      !rst_req.full |=> $stable(wdt_cnt_r))
    else $error("counter moved with bad key");
  a_run_timeout: assert property (s_run_ovf |=> full_reset_r && // R8
      to_flag_r && pc_sp_clear_r)
    else $error("running timeout missed full reset");
  a_sleep_timeout: assert property (s_sleep_ovf |=> !full_reset_r && // R9
      pc_sp_clear_r && to_flag_r)
    else $error("sleep timeout wrong reset");
  a_clear_count: assert property (clear_any |=> wdt_cnt_r == 18'h0) // R10
    else $error("counter not cleared");
  a_lvr_filter: assert property (lvr_fire |-> // R12
      brown_cnt_r == `BROWN_CNT_W'(`BROWNOUT_CYCLES) && $past(ls_sync_r))
    else $error("brownout fired before filter time");
  a_lvr_flag: assert property (lvr_fire |=> lv_flag_r && full_reset_r) // R13
    else $error("brownout flag not set");
  a_lvr_sleep: assert property (low_power_mode |=> // R14
      brown_cnt_r == 10'h000)
    else $error("brownout filter ran in low power");
  a_lvr_keeps: assert property (lvr_fire && !wdt_ovf && !halt_instr && // R20
      !clear_watchdog_instr |=> $stable(to_flag_r) && $stable(pdf_r))
    else $error("brownout changed status flags");
  a_iap_reset: assert property (iap_fire |=> full_reset_r) // R17
    else $error("programming key write gave no reset");
  a_reset_source_flags_zero: assert property (rd && addr == // R18
      `ADDR_RESET_SOURCE_FLAGS |=> rdata_r[7:3] == 5'h00 && !rdata_r[1])
    else $error("unused reset flag bits not zero");
  a_halt_flags: assert property (halt_instr && !wdt_ovf |=> // R19
      pdf_r && !to_flag_r)
    else $error("halt flags wrong");
  a_ovf_pulse: assert property (wdt_ovf |=> !wdt_ovf) // R22
    else $error("overflow longer than one cycle");
endmodule

// ===== sim/core_model.sv
// Processor core model: register port master and instruction pulses
`timescale 1ns/1ns
module core_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata,
  // Instruction events
  output logic clear_watchdog_instr,
  output logic halt_instr
);
  // Idle bus at time zero
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    clear_watchdog_instr = 1'b0;
    halt_instr = 1'b0;
  end

  // One-cycle write strobe beside address and data
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Clear instruction, issued before the period runs out
  task automatic do_clear;
    @(posedge clk);
    clear_watchdog_instr <= 1'b1;
    @(posedge clk);
    clear_watchdog_instr <= 1'b0;
    #1;
  endtask

  // Halt instruction pulse
  task automatic do_halt;
    @(posedge clk);
    halt_instr <= 1'b1;
    @(posedge clk);
    halt_instr <= 1'b0;
    #1;
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the watchdog and reset flag block
`timescale 1ns/1ns
module testbench;
  logic clk, rstn, lsc, low_supply, lpm, wr, rd, clr, halt;
  logic full_reset, pc_sp_clear, tmo_flag, pd_flag;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, port_data, port_dir;
  int n_fail, comparisons, n_rst, n_pcsp, base;

  watchdog_and_reset_flags u_dut (
    .clk(clk), .rstn(rstn), .low_speed_clock(lsc),
    .low_supply(low_supply), .clear_watchdog_instr(clr),
    .halt_instr(halt), .low_power_mode(lpm), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .full_reset(full_reset), .pc_sp_clear(pc_sp_clear),
    .timeout_status_flag(tmo_flag), .power_down_flag(pd_flag),
    .port_data(port_data), .port_dir(port_dir)
  );
  core_model u_core (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .clear_watchdog_instr(clr), .halt_instr(halt)
  );

  // Clock and time-zero inputs
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    lsc = 1'b0;
    low_supply = 1'b0;
    lpm = 1'b0;
    forever #50 clk = ~clk;
  end

  // Count reset pulses outside power-on reset
  always @(posedge clk) begin
    if (rstn === 1'b1 && full_reset === 1'b1) n_rst++;
    if (rstn === 1'b1 && pc_sp_clear === 1'b1) n_pcsp++;
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(string what, logic [2:0] a, logic [7:0] exp);
    logic [7:0] v;
    u_core.read_reg(a, v);
    check(what, v, exp);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Oscillator edges, slow enough for the two-flop synchroniser
  task automatic ticks(int n);
    repeat (n) begin
      @(posedge clk) lsc <= 1'b1;
      repeat (4) @(posedge clk);
      lsc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // Bounded wait for one more reset pulse
  task automatic wait_rst(int limit);
    int b;
    b = n_rst;
    for (int i = 0; i < limit && n_rst == b; i++) @(posedge clk);
    #1;
    check("reset pulse", 8'(n_rst - b), 8'h01);
    if (n_rst == b) stop_test();
  endtask

  task automatic t_power_on;
    check("port data", port_data, 8'hff);
    check("port dir", port_dir, 8'hff);
    check("pc clear", {7'h00, pc_sp_clear}, 8'h00);
    rd_chk("control", 3'h0, 8'h53);
    rd_chk("flags", 3'h1, 8'h00);
    rd_chk("status", 3'h5, 8'h00);
    rd_chk("unmapped", 3'h6, 8'h00);
    $display("power-on test done");
  endtask

  task automatic t_timeout;
    for (int s = 1; s < 8; s++) begin
      u_core.write_reg(3'h0, 8'h50 | 8'(s));
      rd_chk("selector", 3'h0, 8'h50 | 8'(s));
    end
    ticks(300);
    u_core.write_reg(3'h3, 8'h12);
    u_core.write_reg(3'h4, 8'h34);
    u_core.write_reg(3'h0, 8'h50);
    check("dir written", port_dir, 8'h34);
    base = n_rst;
    ticks(255);
    check("early reset", 8'(n_rst - base), 8'h00);
    ticks(1);
    check("timeout reset", 8'(n_rst - base), 8'h01);
    check("timeout flag", {7'h00, tmo_flag}, 8'h01);
    check("port reload", port_data, 8'hff);
    check("dir reload", port_dir, 8'hff);
    rd_chk("control reload", 3'h0, 8'h53);
    $display("timeout test done");
  endtask

  task automatic t_clear;
    base = n_rst;
    u_core.write_reg(3'h0, 8'h50);
    ticks(200);
    u_core.do_clear();
    ticks(200);
    u_core.do_halt();
    check("halt pd", {7'h00, pd_flag}, 8'h01);
    check("halt to", {7'h00, tmo_flag}, 8'h00);
    ticks(200);
    u_core.write_reg(3'h0, 8'ha8);
    ticks(200);
    u_core.do_clear();
    check("clear pd", {7'h00, pd_flag}, 8'h00);
    check("no reset", 8'(n_rst - base), 8'h00);
    $display("clear test done");
  endtask

  task automatic t_low_power;
    @(posedge clk) lpm <= 1'b1;
    u_core.write_reg(3'h0, 8'h50);
    base = n_rst;
    n_pcsp = 0;
    ticks(256);
    check("lp full", 8'(n_rst - base), 8'h00);
    check("lp pc clear", 8'(n_pcsp), 8'h01);
    check("lp to", {7'h00, tmo_flag}, 8'h01);
    low_supply <= 1'b1;
    repeat (1200) @(posedge clk);
    low_supply <= 1'b0;
    repeat (5) @(posedge clk);
    lpm <= 1'b0;
    check("lp brownout", 8'(n_rst - base), 8'h00);
    $display("low power test done");
  endtask

  task automatic t_brownout;
    base = n_rst;
    @(posedge clk) low_supply <= 1'b1;
    repeat (500) @(posedge clk);
    low_supply <= 1'b0;
    repeat (10) @(posedge clk);
    check("short dip", 8'(n_rst - base), 8'h00);
    low_supply <= 1'b1;
    wait_rst(1100);
    @(posedge clk) low_supply <= 1'b0;
    repeat (5) @(posedge clk);
    rd_chk("lv flag", 3'h1, 8'h04);
    rd_chk("flags kept", 3'h5, 8'h02);
    $display("brownout test done");
  endtask

  task automatic t_key;
    u_core.write_reg(3'h1, 8'h00);
    rd_chk("flags cleared", 3'h1, 8'h00);
    base = n_rst;
    u_core.write_reg(3'h0, 8'h00);
    repeat (90) @(posedge clk);
    check("key delay", 8'(n_rst - base), 8'h00);
    wait_rst(40);
    rd_chk("soft flag", 3'h1, 8'h01);
    u_core.write_reg(3'h1, 8'hff);
    rd_chk("unused bits", 3'h1, 8'h05);
    u_core.write_reg(3'h1, 8'h00);
    rd_chk("soft cleared", 3'h1, 8'h00);
    $display("key test done");
  endtask

  task automatic t_prog;
    base = n_rst;
    u_core.write_reg(3'h2, 8'h54);
    repeat (5) @(posedge clk);
    check("other value", 8'(n_rst - base), 8'h00);
    u_core.write_reg(3'h2, 8'h55);
    wait_rst(5);
    $display("programming reset test done");
  endtask

  // Mid-run power-on reset must clear the timeout flag left set
  task automatic t_por;
    rd_chk("status before", 3'h5, 8'h02);
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("por pc clear", {7'h00, pc_sp_clear}, 8'h01);
    @(posedge clk) rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("por pc release", {7'h00, pc_sp_clear}, 8'h00);
    rd_chk("por status", 3'h5, 8'h00);
    rd_chk("por control", 3'h0, 8'h53);
    $display("power-on reset test done");
  endtask

  // Hang guard
  initial begin
    #6000000;
    n_fail++;
    $display("mismatch run time expected end seen timeout");
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 check("pc clear in reset", {7'h00, pc_sp_clear}, 8'h01);
    @(posedge clk) rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_power_on();
    t_timeout();
    t_clear();
    t_low_power();
    t_brownout();
    t_key();
    t_prog();
    t_por();
    stop_test();
  end
endmodule
